/* twras_pkg.sv */
// shared constants and state types for the two-wire register access link
// assumes a 100 MHz system clock on both ends of the link
package twras_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS = 10;
  // serial clock made by the master end; slow enough for the slave's synchroniser
  localparam int SCL_PERIOD_NS = 400;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  // ==========================================================
  // addressing
  localparam logic [7:0] ADDR_W_DEFAULT = 8'hBA;
  localparam logic [7:0] ADDR_W_ALT = 8'h90;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ==========================================================
  // framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [1:0] Q_LOW = 2'h0;
  localparam logic [1:0] Q_SET = 2'h1;
  localparam logic [1:0] Q_HIGH = 2'h2;
  localparam logic [1:0] Q_SAMPLE = 2'h3;
  // master byte sequence positions
  localparam logic [2:0] SEQ_ADDR_W = 3'h0;
  localparam logic [2:0] SEQ_PTR = 3'h1;
  localparam logic [2:0] SEQ_SECOND = 3'h2;
  localparam logic [2:0] SEQ_RX_FIRST = 3'h3;
  localparam logic [2:0] SEQ_LAST_W = 3'h3;
  localparam logic [2:0] SEQ_LAST_R = 3'h4;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_RDATA, S_MACK, S_WAIT
  } twras_sst_t;

  typedef enum logic [1:0] {
    M_IDLE, M_START, M_BYTE, M_STOP
  } twras_mst_t;

endpackage

/* twras_if.sv */
// two-wire link between the register slave and its master
// assumes an off-chip pull-up on both lines: a line is low only while some end pulls it low
interface twras_if;
  logic scl_o;
  logic scl_oe;
  logic msda_o;
  logic msda_oe;
  logic ssda_o;
  logic ssda_oe;
  logic scl;
  logic serial_data_line;

  // ==========================================================
  // wired-and resolution of both lines
  assign scl = (scl_oe & ~scl_o) ? 1'b0 : 1'b1;
  assign serial_data_line = ~((msda_oe & ~msda_o) | (ssda_oe & ~ssda_o));

  modport dev (
    input scl,
    input serial_data_line,
    output ssda_o,
    output ssda_oe
  );

  modport mst (
    input serial_data_line,
    output scl_o,
    output scl_oe,
    output msda_o,
    output msda_oe
  );
endinterface

/* twras_slave.sv */
// register access slave end of the two-wire link
// assumes the master makes the serial clock; both lines are sampled on the system clock
//
// Functional notes
// - master opens every transaction with start
// - address byte lsb: 0 write, 1 read
// - matching address is acknowledged by device
// - write: pointer byte follows address
// - pointer byte is acknowledged
// - every written byte is acknowledged
// - two bytes form one 16-bit register
// - pointer advances after each written register
// - start or stop ends a write burst
// - read: pointer loaded by a write first
// - repeated start, read address, bytes out
// - master acknowledges each byte it reads but the last
// - pointer advances after each read register
// - master no-acknowledge ends read, line released
// - idle means both lines high
// - start: data falls while clock high
// - stop: data rises while clock high
// - default address pair, alternate by pin/bit
module twras_slave (
  input wire logic clock,
  input wire logic nrst,
  twras_if.dev bus,
  input wire logic alternate_id_select_pin,
  input wire logic alt_id_ctrl,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data
);

  // ==========================================================
  // input synchronisers
  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_s3_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_s3_r;
  logic pin_s1_r;
  logic pin_s2_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // reset to the idle level so no false start is seen at release
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      scl_s1_r <= bus.scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= bus.serial_data_line;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      pin_s1_r <= alternate_id_select_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==========================================================
  // line events
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] my_addr;

  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign start_ev = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_ev = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
  // alternate pair when pin and control bit agree
  assign my_addr = (pin_s2_r == alt_id_ctrl) ? twras_pkg::ADDR_W_ALT
                                             : twras_pkg::ADDR_W_DEFAULT;

  function automatic logic [7:0] tx_byte(input logic lower, input logic [15:0] word);
    tx_byte = lower ? word[7:0] : word[15:8];
  endfunction

  // ==========================================================
  // transaction sequencer
  twras_pkg::twras_sst_t st_r;
  twras_pkg::twras_sst_t st_nxt;
  twras_pkg::twras_sst_t after_r;
  twras_pkg::twras_sst_t after_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic half_r;
  logic half_nxt;
  logic mack_r;
  logic mack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic o_r;
  logic o_nxt;
  logic wr_en_r;
  logic wr_en_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [15:0] wr_data_r;
  logic [15:0] wr_data_nxt;
  logic [7:0] tx_v;

  always_comb begin
    st_nxt = st_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    hi_nxt = hi_r;
    half_nxt = half_r;
    mack_nxt = mack_r;
    oe_nxt = oe_r;
    o_nxt = o_r;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    // rd_data follows rd_addr, which is the registered pointer
    tx_v = tx_byte(half_r, rd_data);
    if (stop_ev) begin
      st_nxt = twras_pkg::S_IDLE;
      oe_nxt = 1'b0;
      o_nxt = 1'b1;
    end else if (start_ev) begin
      // a repeated start also lands here and drops any burst in flight
      st_nxt = twras_pkg::S_ADDR;
      cnt_nxt = 4'h0;
      half_nxt = 1'b0;
      oe_nxt = 1'b0;
      o_nxt = 1'b1;
    end else if (scl_rise) begin
      case (st_r)
        twras_pkg::S_ADDR, twras_pkg::S_PTR, twras_pkg::S_WDATA: begin
          sh_nxt = {sh_r[6:0], sda_s2_r};
          cnt_nxt = cnt_r + 4'h1;
        end
        twras_pkg::S_MACK: begin
          mack_nxt = ~sda_s2_r;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        twras_pkg::S_ADDR: begin
          if (cnt_r == twras_pkg::BITS_PER_BYTE) begin
            if (sh_r[7:1] == my_addr[7:1]) begin
              st_nxt = twras_pkg::S_ACK;
              oe_nxt = 1'b1;
              o_nxt = 1'b0;
              after_nxt = (sh_r[0] == twras_pkg::DIR_READ) ? twras_pkg::S_RDATA
                                                          : twras_pkg::S_PTR;
            end else begin
              st_nxt = twras_pkg::S_WAIT;
            end
          end
        end
        twras_pkg::S_PTR: begin
          if (cnt_r == twras_pkg::BITS_PER_BYTE) begin
            ptr_nxt = sh_r;
            half_nxt = 1'b0;
            st_nxt = twras_pkg::S_ACK;
            oe_nxt = 1'b1;
            o_nxt = 1'b0;
            after_nxt = twras_pkg::S_WDATA;
          end
        end
        twras_pkg::S_WDATA: begin
          if (cnt_r == twras_pkg::BITS_PER_BYTE) begin
            st_nxt = twras_pkg::S_ACK;
            oe_nxt = 1'b1;
            o_nxt = 1'b0;
            after_nxt = twras_pkg::S_WDATA;
            if (!half_r) begin
              hi_nxt = sh_r;
              half_nxt = 1'b1;
            end else begin
              wr_en_nxt = 1'b1;
              wr_addr_nxt = ptr_r;
              wr_data_nxt = {hi_r, sh_r};
              ptr_nxt = ptr_r + twras_pkg::PTR_STEP;
              half_nxt = 1'b0;
            end
          end
        end
        twras_pkg::S_ACK: begin
          st_nxt = after_r;
          cnt_nxt = 4'h0;
          if (after_r == twras_pkg::S_RDATA) begin
            oe_nxt = 1'b1;
            o_nxt = tx_v[7];
            sh_nxt = {tx_v[6:0], 1'b0};
            cnt_nxt = 4'h1;
          end else begin
            oe_nxt = 1'b0;
            o_nxt = 1'b1;
          end
        end
        twras_pkg::S_RDATA: begin
          if (cnt_r == twras_pkg::BITS_PER_BYTE) begin
            // free the line for the master's acknowledge slot
            st_nxt = twras_pkg::S_MACK;
            oe_nxt = 1'b0;
            o_nxt = 1'b1;
            half_nxt = ~half_r;
            if (half_r) begin
              ptr_nxt = ptr_r + twras_pkg::PTR_STEP;
            end
          end else begin
            o_nxt = sh_r[7];
            sh_nxt = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        twras_pkg::S_MACK: begin
          if (mack_r) begin
            st_nxt = twras_pkg::S_RDATA;
            oe_nxt = 1'b1;
            o_nxt = tx_v[7];
            sh_nxt = {tx_v[6:0], 1'b0};
            cnt_nxt = 4'h1;
          end else begin
            st_nxt = twras_pkg::S_WAIT;
            oe_nxt = 1'b0;
            o_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= twras_pkg::S_IDLE;
      after_r <= twras_pkg::S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      hi_r <= 8'h00;
      half_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      o_r <= 1'b1;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      hi_r <= hi_nxt;
      half_r <= half_nxt;
      mack_r <= mack_nxt;
      oe_r <= oe_nxt;
      o_r <= o_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign bus.ssda_o = o_r;
  assign bus.ssda_oe = oe_r;
  assign wr_en = wr_en_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
  assign rd_addr = ptr_r;

endmodule // twras_slave

/* twras_master.sv */
// master end of the two-wire link: one 16-bit register write or read per command
// assumes a 100 MHz clock; it makes the serial clock itself by dividing that clock
module twras_master (
  input wire logic clock,
  input wire logic nrst,
  twras_if.mst bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_alt,
  input wire logic [7:0] cmd_ptr,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic nack_err,
  output logic [15:0] rdata
);

  // ==========================================================
  // data line synchroniser
  logic sda_s1_r;
  logic sda_s2_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.serial_data_line;
      sda_s2_r <= sda_s1_r;
    end
  end

  function automatic logic [7:0] seq_byte(input logic [2:0] seq, input logic rd,
                                          input logic [7:0] base, input logic [7:0] ptr,
                                          input logic [15:0] wd);
    case (seq)
      twras_pkg::SEQ_ADDR_W: seq_byte = {base[7:1], twras_pkg::DIR_WRITE};
      twras_pkg::SEQ_PTR: seq_byte = ptr;
      twras_pkg::SEQ_SECOND: seq_byte = rd ? {base[7:1], twras_pkg::DIR_READ} : wd[15:8];
      default: seq_byte = wd[7:0];
    endcase
  endfunction

  // ==========================================================
  // sequencer
  twras_pkg::twras_mst_t st_r;
  twras_pkg::twras_mst_t st_nxt;
  logic [7:0] qcnt_r;
  logic [7:0] qcnt_nxt;
  logic [1:0] q_r;
  logic [1:0] q_nxt;
  logic [2:0] seq_r;
  logic [2:0] seq_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic rd_r;
  logic rd_nxt;
  logic [7:0] base_r;
  logic [7:0] base_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [15:0] wd_r;
  logic [15:0] wd_nxt;
  logic scl_o_r;
  logic scl_o_nxt;
  logic scl_oe_r;
  logic scl_oe_nxt;
  logic sda_o_r;
  logic sda_o_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic ready_r;
  logic ready_nxt;
  logic done_r;
  logic done_nxt;
  logic err_r;
  logic err_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic tick;
  logic rx;
  logic last;

  assign tick = (qcnt_r == twras_pkg::QTR_LAST);
  assign rx = rd_r && (seq_r >= twras_pkg::SEQ_RX_FIRST);
  assign last = (seq_r == (rd_r ? twras_pkg::SEQ_LAST_R : twras_pkg::SEQ_LAST_W));

  always_comb begin
    st_nxt = st_r;
    qcnt_nxt = tick ? 8'h00 : qcnt_r + 8'h01;
    q_nxt = q_r;
    seq_nxt = seq_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    base_nxt = base_r;
    ptr_nxt = ptr_r;
    wd_nxt = wd_r;
    scl_o_nxt = scl_o_r;
    scl_oe_nxt = scl_oe_r;
    sda_o_nxt = sda_o_r;
    sda_oe_nxt = sda_oe_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    err_nxt = err_r;
    rdata_nxt = rdata_r;
    if (st_r == twras_pkg::M_IDLE) begin
      if (cmd_valid && ready_r) begin
        st_nxt = twras_pkg::M_START;
        q_nxt = twras_pkg::Q_LOW;
        qcnt_nxt = 8'h00;
        seq_nxt = twras_pkg::SEQ_ADDR_W;
        rd_nxt = cmd_read;
        base_nxt = cmd_alt ? twras_pkg::ADDR_W_ALT : twras_pkg::ADDR_W_DEFAULT;
        ptr_nxt = cmd_ptr;
        wd_nxt = cmd_wdata;
        ready_nxt = 1'b0;
        err_nxt = 1'b0;
        scl_oe_nxt = 1'b1;
        scl_o_nxt = 1'b1;
        sda_oe_nxt = 1'b1;
        sda_o_nxt = 1'b1;
      end
    end else if (tick) begin
      q_nxt = q_r + 2'h1;
      case (st_r)
        twras_pkg::M_START: begin
          case (q_r)
            twras_pkg::Q_LOW: scl_o_nxt = 1'b0;
            twras_pkg::Q_SET: begin
              sda_oe_nxt = 1'b1;
              sda_o_nxt = 1'b1;
            end
            twras_pkg::Q_HIGH: scl_o_nxt = 1'b1;
            default: begin
              sda_o_nxt = 1'b0;
              st_nxt = twras_pkg::M_BYTE;
              bit_nxt = 4'h0;
              sh_nxt = seq_byte(seq_r, rd_r, base_r, ptr_r, wd_r);
            end
          endcase
        end
        twras_pkg::M_BYTE: begin
          case (q_r)
            twras_pkg::Q_LOW: scl_o_nxt = 1'b0;
            twras_pkg::Q_SET: begin
              if (bit_r < twras_pkg::BITS_PER_BYTE) begin
                sda_oe_nxt = ~rx;
                sda_o_nxt = rx ? 1'b1 : sh_r[7];
              end else begin
                // acknowledge all but the final read byte
                sda_oe_nxt = rx;
                sda_o_nxt = ~rx | last;
              end
            end
            twras_pkg::Q_HIGH: scl_o_nxt = 1'b1;
            default: begin
              if (bit_r < twras_pkg::BITS_PER_BYTE) begin
                sh_nxt = {sh_r[6:0], sda_s2_r};
                bit_nxt = bit_r + 4'h1;
              end else if (!rx && sda_s2_r) begin
                err_nxt = 1'b1;
                st_nxt = twras_pkg::M_STOP;
              end else begin
                if (rx) begin
                  rdata_nxt = {rdata_r[7:0], sh_r};
                end
                if (last) begin
                  st_nxt = twras_pkg::M_STOP;
                end else begin
                  seq_nxt = seq_r + 3'h1;
                  bit_nxt = 4'h0;
                  sh_nxt = seq_byte(seq_r + 3'h1, rd_r, base_r, ptr_r, wd_r);
                  if (rd_r && (seq_r == twras_pkg::SEQ_PTR)) begin
                    st_nxt = twras_pkg::M_START;
                  end
                end
              end
            end
          endcase
        end
        twras_pkg::M_STOP: begin
          case (q_r)
            twras_pkg::Q_LOW: scl_o_nxt = 1'b0;
            twras_pkg::Q_SET: begin
              sda_oe_nxt = 1'b1;
              sda_o_nxt = 1'b0;
            end
            twras_pkg::Q_HIGH: scl_o_nxt = 1'b1;
            default: begin
              // data rises with clock high in the same cycle that both lines are let go
              sda_o_nxt = 1'b1;
              sda_oe_nxt = 1'b0;
              scl_oe_nxt = 1'b0;
              st_nxt = twras_pkg::M_IDLE;
              ready_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
        default: st_nxt = twras_pkg::M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= twras_pkg::M_IDLE;
      qcnt_r <= 8'h00;
      q_r <= 2'h0;
      seq_r <= 3'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      base_r <= 8'h00;
      ptr_r <= 8'h00;
      wd_r <= 16'h0000;
      scl_o_r <= 1'b1;
      scl_oe_r <= 1'b0;
      sda_o_r <= 1'b1;
      sda_oe_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      qcnt_r <= qcnt_nxt;
      q_r <= q_nxt;
      seq_r <= seq_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      base_r <= base_nxt;
      ptr_r <= ptr_nxt;
      wd_r <= wd_nxt;
      scl_o_r <= scl_o_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_o_r <= sda_o_nxt;
      sda_oe_r <= sda_oe_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus.scl_o = scl_o_r;
  assign bus.scl_oe = scl_oe_r;
  assign bus.msda_o = sda_o_r;
  assign bus.msda_oe = sda_oe_r;
  assign cmd_ready = ready_r;
  assign done = done_r;
  assign nack_err = err_r;
  assign rdata = rdata_r;

endmodule // twras_master

/* twras_asserts.sv */
// wire-level checks of the two-wire register link between master and slave ends
// assumes one system clock for both ends and the resolved lines of twras_if
module twras_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic msda_o,
  input wire logic msda_oe,
  input wire logic ssda_o,
  input wire logic ssda_oe,
  input wire logic scl,
  input wire logic serial_data_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] drv_cnt_r;
  logic [8:0] drv_cnt_nxt;

  // ==========================================================
  // length of one unbroken slave drive, saturating
  always_comb begin
    drv_cnt_nxt = 9'h000;
    if (ssda_oe && drv_cnt_r != 9'h1FF) begin
      drv_cnt_nxt = drv_cnt_r + 9'h001;
    end else if (ssda_oe) begin
      drv_cnt_nxt = drv_cnt_r;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drv_cnt_r <= 9'h000;
    end else begin
      drv_cnt_r <= drv_cnt_nxt;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // slave may only change its drive while the clock is low
  slave_hold_a: assert property (scl && $past(scl) |-> $stable(ssda_oe && !ssda_o))
    else $error("slave drive changed while clock high");
  ack_delay_a: assert property ($rose(ssda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("slave drive began too soon after clock fall");
  idle_lines_a: assert property (!scl_oe && !msda_oe |-> scl && serial_data_line)
    else $error("released bus not idle high");
  slave_gated_a: assert property (!scl_oe |-> !ssda_oe)
    else $error("slave drives outside a transaction");
  start_free_a: assert property (scl && $past(scl) && $fell(serial_data_line) |-> !ssda_oe)
    else $error("start condition not made by master alone");
  stop_free_a: assert property (scl && $past(scl) && $rose(serial_data_line) |-> !ssda_oe)
    else $error("slave drives at stop condition");
  start_first_a: assert property ($rose(scl_oe) |-> ##[1:45] (scl && $fell(serial_data_line)))
    else $error("transaction did not open with start");
  // address ack plus eight read bits, 40 cycles a slot, plus slack; longer means never released
  drive_bound_a: assert property (drv_cnt_r <= 9'h170)
    else $error("slave held data line too long");
endmodule // twras_asserts

/* testbench.sv */
// self-checking bench: master and slave ends joined by one twras_if
// assumes the slave's register store is the bench memory behind rd_data
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic nrst;
  logic alternate_id_select_pin;
  logic alt_id_ctrl;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic cmd_valid;
  logic cmd_read;
  logic cmd_alt;
  logic [7:0] cmd_ptr;
  logic [15:0] cmd_wdata;
  logic cmd_ready;
  logic done;
  logic nack_err;
  logic [15:0] rdata;
  logic [15:0] mem [256];
  logic [7:0] first_byte;
  int bit_n = 9;
  int wr_seen = 0;
  int fail_count = 0;
  int checks = 0;

  twras_if bus ();

  twras_slave twras_slave_i (.clock(clock), .nrst(nrst), .bus(bus),
    .alternate_id_select_pin(alternate_id_select_pin), .alt_id_ctrl(alt_id_ctrl),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));

  twras_master twras_master_i (.clock(clock), .nrst(nrst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_alt(cmd_alt), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .done(done), .nack_err(nack_err), .rdata(rdata));

  twras_asserts twras_asserts_i (.clock(clock), .nrst(nrst), .scl_o(bus.scl_o),
    .scl_oe(bus.scl_oe), .msda_o(bus.msda_o), .msda_oe(bus.msda_oe), .ssda_o(bus.ssda_o),
    .ssda_oe(bus.ssda_oe), .scl(bus.scl), .serial_data_line(bus.serial_data_line));

  // ==========================================================
  // clock, register store, wire monitor
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  assign rd_data = mem[rd_addr];

  always @(posedge clock) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr] <= wr_data;
      wr_seen++;
    end
  end

  // first byte after each start, as seen on the wire
  always @(negedge bus.serial_data_line) begin
    if (bus.scl === 1'b1) begin
      bit_n = 0;
    end
  end

  always @(posedge bus.scl) begin
    if (bit_n < 8) begin
      first_byte = {first_byte[6:0], bus.serial_data_line};
    end
    bit_n++;
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one command through the master; entered and left just after a clock edge
  task automatic run(input logic rd, input logic alt, input logic [7:0] ptr,
                     input logic [15:0] wd);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    cmd_read = rd;
    cmd_alt = alt;
    cmd_ptr = ptr;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 6000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 6000) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    end
    repeat (4) @(posedge clock);
    #1;
  endtask

  // ==========================================================
  // watchdog: twelve commands of at most some 2000 cycles each, doubled
  initial begin
    #480us;
    fail_count++;
    test_done();
  end

  // ==========================================================
  // tests
  initial begin
    int w;
    logic alt;
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
    nrst = 1'b0;
    alternate_id_select_pin = 1'b1;
    alt_id_ctrl = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_alt = 1'b0;
    cmd_ptr = 8'h00;
    cmd_wdata = 16'h0000;
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'b1;
    @(posedge clock);
    #1;
    check({bus.scl, bus.serial_data_line}, 2'h3);

    w = wr_seen;
    run(1'b0, 1'b0, 8'h12, 16'hA55A);
    check(16'(wr_seen - w), 16'h0001);
    check(wr_addr, 8'h12);
    check(wr_data, 16'hA55A);
    check(rd_addr, 8'h13);
    check(nack_err, 1'b0);
    check(first_byte, 8'hBA);
    $display("test write done");

    run(1'b1, 1'b0, 8'h12, 16'h0000);
    check(rdata, 16'hA55A);
    check(rd_addr, 8'h13);
    check(nack_err, 1'b0);
    check(first_byte, 8'hBB);
    check({bus.scl, bus.serial_data_line}, 2'h3);
    $display("test read done");

    run(1'b0, 1'b0, 8'hFF, 16'h0001);
    check(rd_addr, 8'h00);
    run(1'b1, 1'b0, 8'hFF, 16'h0000);
    check(rdata, 16'h0001);
    check(rd_addr, 8'h00);
    $display("test wrap done");

    for (int k = 0; k < 4; k++) begin
      alternate_id_select_pin = k[1];
      alt_id_ctrl = k[0];
      alt = (k[1] == k[0]);
      repeat (4) @(posedge clock);
      #1;
      w = wr_seen;
      run(1'b0, ~alt, 8'h40, 16'h1111);
      check(nack_err, 1'b1);
      check(16'(wr_seen - w), 16'h0000);
      run(1'b0, alt, 8'h40, {8'h5A, 6'h00, k[1:0]});
      check(nack_err, 1'b0);
      check(16'(wr_seen - w), 16'h0001);
      check(wr_data, {8'h5A, 6'h00, k[1:0]});
      check(first_byte, alt ? 8'h90 : 8'hBA);
    end
    $display("test address select done");
    test_done();
  end
endmodule // testbench
